// [rtl/ubr_baud_gen.sv]
/*
  fractional baud tick generator giving eight ticks per bit.
  assumes the divisor is static while the port is in use.
*/
`timescale 1ns/1ps
module ubr_baud_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [15:0] divisor,
  output logic os_tick
);

  localparam logic [18:0] MOD = 19'(ubr_pkg::ACC_MOD);

  logic [18:0] acc_r;
  logic [18:0] acc_nxt;
  logic [18:0] step;

  assign step = {divisor, 3'h0};
  assign acc_nxt = acc_r + step;

  // accumulate divisor*8 against the 4096 us unit scaled to the clock
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      acc_r <= 19'h00000;
      os_tick <= 1'b0;
    end else if (acc_nxt >= MOD) begin
      acc_r <= acc_nxt - MOD;
      os_tick <= 1'b1;
    end else begin
      acc_r <= acc_nxt;
      os_tick <= 1'b0;
    end
  end

endmodule

// [rtl/ubr_pkg.sv]
/*
  constants and state types for the serial port with break reset and bypass.
  assumes a single 50 MHz system clock with a synchronous active-low reset.
*/
package ubr_pkg;

  // system clock
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_NS = 20;

  // rate = divisor / 0.004096 s, i.e. the rate unit is 4096 us
  localparam int unsigned RATE_UNIT_US = 4096;
  localparam int unsigned OVERSAMPLE = 8;
  localparam int unsigned ACC_MOD = (CLK_HZ / 1_000_000) * RATE_UNIT_US;
  localparam int unsigned ACC_W = 19;
  localparam int unsigned DIV_W = 16;

  // typical divisor settings
  localparam logic [15:0] DIV_115200 = 16'h01D8;
  localparam logic [15:0] DIV_921600 = 16'h0EBF;

  // character format
  localparam int unsigned DATA_W = 8;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [2:0] OS_HALF = 3'h3;
  localparam logic [2:0] OS_LAST = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // break timeout counted in milliseconds
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
  localparam int unsigned MS_W = 17;

  // pin positions inside general purpose pins 7..4
  localparam int unsigned GP_TX = 0;
  localparam int unsigned GP_RX = 1;
  localparam int unsigned GP_RTS = 2;
  localparam int unsigned GP_CTS = 3;

  typedef enum logic [2:0] {
    UBR_RX_IDLE = 3'b000,
    UBR_RX_START = 3'b001,
    UBR_RX_DATA = 3'b010,
    UBR_RX_PAR = 3'b011,
    UBR_RX_STOP = 3'b100
  } ubr_rx_state_t;

  typedef enum logic [2:0] {
    UBR_TX_IDLE = 3'b000,
    UBR_TX_START = 3'b001,
    UBR_TX_DATA = 3'b010,
    UBR_TX_PAR = 3'b011,
    UBR_TX_STOP = 3'b100,
    UBR_TX_BRK = 3'b101
  } ubr_tx_state_t;

endpackage

// [rtl/ubr_uart.sv]
/*
  serial port: 8-bit characters, parity, 1/2 stop bits, active-low flow control,
  break-triggered reset request, break transmit and latched bypass to pins 7..4.
  assumes a 50 MHz clock, synchronous reset, pin inputs from outside the clock.
*/
// What this block does
// - optional request/clear-to-send flow control
// - flow control pins are active low
// - 8 data bits, parity, 1/2 stops
// - rates from 1200 baud to 4 Mbaud
// - rate equals divisor over 0.004096
// - standard and nonstandard divisors accepted
// - long receive low requests device reset
// - device can transmit a break
// - pins float while reset is held
// - own port routed by default after reset
// - bypass command routes host to pins 7..4
// - bypass enters deep sleep until reset
// - only reset leaves bypass
`timescale 1ns/1ps
module ubr_uart #(
  parameter int unsigned MS_CYCLES = ubr_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] baud_divisor_setting,
  input wire logic [1:0] parity_mode,
  input wire logic two_stop_bits,
  input wire logic flow_ctrl_en,
  input wire logic [15:0] break_reset_timeout_setting,
  input wire logic send_break,
  input wire logic host_control_command_bypass,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_parity_err,
  output logic rx_frame_err,
  input wire logic rx_ready,
  output logic break_reset_req,
  output logic deep_sleep,
  input wire logic uart_rx_i,
  output logic uart_tx_o,
  output logic uart_tx_oe,
  input wire logic uart_cts_n_i,
  output logic uart_rts_n_o,
  output logic uart_rts_n_oe,
  input wire logic [3:0] general_purpose_pins_i,
  output logic [3:0] general_purpose_pins_o,
  output logic [3:0] general_purpose_pins_oe
);

  localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);

  logic bypass_r;
  logic os_tick;
  logic rx_meta_r;
  logic rx_s_r;
  logic cts_meta_r;
  logic cts_n_s_r;
  ubr_pkg::ubr_rx_state_t rx_st_r;
  logic [2:0] rx_os_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_par_r;
  ubr_pkg::ubr_tx_state_t tx_st_r;
  logic [2:0] tx_os_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic tx_par_r;
  logic tx_stop2_r;
  logic tx_line_r;
  logic rts_n_r;
  logic [16:0] ms_pre_r;
  logic [15:0] brk_ms_r;
  logic brk_fired_r;
  logic par_on;

  assign par_on = (parity_mode != ubr_pkg::PAR_NONE);

  ubr_baud_gen u_baud (
    .clk(clk),
    .rst_n(rst_n),
    .run(!bypass_r),
    .divisor(baud_divisor_setting),
    .os_tick(os_tick)
  );

  // two-stage synchronisers for the receive and clear-to-send pin inputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_meta_r <= 1'b1;
      rx_s_r <= 1'b1;
      cts_meta_r <= 1'b1;
      cts_n_s_r <= 1'b1;
    end else begin
      rx_meta_r <= uart_rx_i;
      rx_s_r <= rx_meta_r;
      cts_meta_r <= uart_cts_n_i;
      cts_n_s_r <= cts_meta_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bypass_r <= 1'b0;
    end else if (host_control_command_bypass) begin
      bypass_r <= 1'b1;
    end
  end

  assign deep_sleep = bypass_r;

  always_ff @(posedge clk) begin
    if (!rst_n || bypass_r) begin
      rx_st_r <= ubr_pkg::UBR_RX_IDLE;
      rx_os_r <= 3'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_par_r <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_parity_err <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (os_tick) begin
        rx_os_r <= rx_os_r + 3'h1;
        case (rx_st_r)
          ubr_pkg::UBR_RX_IDLE: begin
            rx_os_r <= 3'h0;
            if (!rx_s_r) begin
              rx_st_r <= ubr_pkg::UBR_RX_START;
            end
          end
          ubr_pkg::UBR_RX_START: begin
            if (rx_os_r == ubr_pkg::OS_HALF) begin
              rx_os_r <= 3'h0;
              rx_bit_r <= 3'h0;
              rx_par_r <= 1'b0;
              rx_parity_err <= 1'b0;
              rx_st_r <= rx_s_r ? ubr_pkg::UBR_RX_IDLE : ubr_pkg::UBR_RX_DATA;
            end
          end
          ubr_pkg::UBR_RX_DATA: begin
            if (rx_os_r == ubr_pkg::OS_LAST) begin
              rx_sh_r <= {rx_s_r, rx_sh_r[7:1]};
              rx_par_r <= rx_par_r ^ rx_s_r;
              rx_bit_r <= rx_bit_r + 3'h1;
              if (rx_bit_r == ubr_pkg::BIT_LAST) begin
                rx_st_r <= par_on ? ubr_pkg::UBR_RX_PAR : ubr_pkg::UBR_RX_STOP;
              end
            end
          end
          ubr_pkg::UBR_RX_PAR: begin
            if (rx_os_r == ubr_pkg::OS_LAST) begin
              rx_parity_err <= ((rx_par_r ^ rx_s_r) != (parity_mode == ubr_pkg::PAR_ODD));
              rx_st_r <= ubr_pkg::UBR_RX_STOP;
            end
          end
          ubr_pkg::UBR_RX_STOP: begin
            if (rx_os_r == ubr_pkg::OS_LAST) begin
              rx_data <= rx_sh_r;
              rx_frame_err <= !rx_s_r;
              rx_valid <= 1'b1;
              rx_st_r <= ubr_pkg::UBR_RX_IDLE;
            end
          end
          default: begin
            rx_st_r <= ubr_pkg::UBR_RX_IDLE;
          end
        endcase
      end
    end
  end

  assign tx_ready = (tx_st_r == ubr_pkg::UBR_TX_IDLE) && !send_break && !bypass_r
                    && (!flow_ctrl_en || !cts_n_s_r);

  always_ff @(posedge clk) begin
    if (!rst_n || bypass_r) begin
      tx_st_r <= ubr_pkg::UBR_TX_IDLE;
      tx_os_r <= 3'h0;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_par_r <= 1'b0;
      tx_stop2_r <= 1'b0;
      tx_line_r <= 1'b1;
    end else if (tx_st_r == ubr_pkg::UBR_TX_IDLE) begin
      tx_os_r <= 3'h0;
      tx_bit_r <= 3'h0;
      if (send_break) begin
        tx_line_r <= 1'b0;
        tx_st_r <= ubr_pkg::UBR_TX_BRK;
      end else if (tx_valid && tx_ready) begin
        tx_sh_r <= tx_data;
        tx_par_r <= (parity_mode == ubr_pkg::PAR_ODD);
        tx_stop2_r <= two_stop_bits;
        tx_line_r <= 1'b0;
        tx_st_r <= ubr_pkg::UBR_TX_START;
      end
    end else if (tx_st_r == ubr_pkg::UBR_TX_BRK) begin
      if (!send_break) begin
        tx_line_r <= 1'b1;
        tx_st_r <= ubr_pkg::UBR_TX_IDLE;
      end
    end else if (os_tick) begin
      tx_os_r <= tx_os_r + 3'h1;
      if (tx_os_r == ubr_pkg::OS_LAST) begin
        case (tx_st_r)
          ubr_pkg::UBR_TX_START: begin
            tx_line_r <= tx_sh_r[0];
            tx_st_r <= ubr_pkg::UBR_TX_DATA;
          end
          ubr_pkg::UBR_TX_DATA: begin
            tx_par_r <= tx_par_r ^ tx_sh_r[0];
            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == ubr_pkg::BIT_LAST) begin
              tx_line_r <= par_on ? (tx_par_r ^ tx_sh_r[0]) : 1'b1;
              tx_st_r <= par_on ? ubr_pkg::UBR_TX_PAR : ubr_pkg::UBR_TX_STOP;
            end else begin
              tx_line_r <= tx_sh_r[1];
            end
          end
          ubr_pkg::UBR_TX_PAR: begin
            tx_line_r <= 1'b1;
            tx_st_r <= ubr_pkg::UBR_TX_STOP;
          end
          ubr_pkg::UBR_TX_STOP: begin
            tx_line_r <= 1'b1;
            if (tx_stop2_r) begin
              tx_stop2_r <= 1'b0;
            end else begin
              tx_st_r <= ubr_pkg::UBR_TX_IDLE;
            end
          end
          default: begin
            tx_line_r <= 1'b1;
            tx_st_r <= ubr_pkg::UBR_TX_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rts_n_r <= 1'b1;
    end else begin
      rts_n_r <= flow_ctrl_en ? !rx_ready : 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || rx_s_r || bypass_r) begin
      ms_pre_r <= 17'h00000;
      brk_ms_r <= 16'h0000;
    end else if (ms_pre_r == MS_LAST) begin
      ms_pre_r <= 17'h00000;
      if (brk_ms_r != 16'hFFFF) begin
        brk_ms_r <= brk_ms_r + 16'h0001;
      end
    end else begin
      ms_pre_r <= ms_pre_r + 17'h00001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || rx_s_r || bypass_r) begin
      brk_fired_r <= 1'b0;
      break_reset_req <= 1'b0;
    end else if (!brk_fired_r && break_reset_timeout_setting != 16'h0000
                 && brk_ms_r > break_reset_timeout_setting) begin
      brk_fired_r <= 1'b1;
      break_reset_req <= 1'b1;
    end else begin
      break_reset_req <= 1'b0;
    end
  end

  assign uart_tx_o = bypass_r ? general_purpose_pins_i[ubr_pkg::GP_RX] : tx_line_r;
  assign uart_rts_n_o = bypass_r ? general_purpose_pins_i[ubr_pkg::GP_CTS] : rts_n_r;
  assign general_purpose_pins_o = {1'b0, uart_cts_n_i, 1'b0, uart_rx_i};

  assign uart_tx_oe = rst_n;
  assign uart_rts_n_oe = rst_n;
  assign general_purpose_pins_oe = {1'b0, bypass_r & rst_n, 1'b0, bypass_r & rst_n};

endmodule

// [tb/ubr_serial_peer.sv]
/*
  far-side serial device: frames characters onto the receive line and samples
  the transmit line. assumes BIT clocks per bit and an idle-high line.
*/
`timescale 1ns/1ps
module ubr_serial_peer #(
  parameter int BIT = 16
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'h1;
  task automatic send(input logic [7:0] d, input logic [1:0] p, input logic bad,
      input logic stp);
    logic [10:0] f;
    f = (p == ubr_pkg::PAR_NONE) ? {1'h1, stp, d, 1'h0}
      : {stp, ^d ^ (p == ubr_pkg::PAR_ODD) ^ bad, d, 1'h0};
    for (int i = 0; i < 11; i++) begin
      @(negedge clk);
      line_out = f[i];
      repeat (BIT - 1) @(negedge clk);
    end
    line_out = 1'h1;
  endtask
  // listens only, never drives the device line
  task automatic recv(output logic [10:0] s);
    int n;
    n = 0;
    while (line_in !== 1'h0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    repeat (BIT / 2) @(negedge clk);
    for (int i = 0; i < 11; i++) begin
      s[i] = line_in;
      repeat (BIT) @(negedge clk);
    end
  endtask
endmodule

// [tb/ubr_uart_monitor.sv]
/*
  port assertions for the serial port, bound to every instance.
  assumes one clock with a synchronous active-low reset.
*/
`timescale 1ns/1ps
module ubr_uart_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flow_ctrl_en,
  input wire logic host_control_command_bypass,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_ready,
  input wire logic break_reset_req,
  input wire logic deep_sleep,
  input wire logic uart_rx_i,
  input wire logic uart_tx_o,
  input wire logic uart_cts_n_i,
  input wire logic uart_rts_n_o,
  input wire logic [3:0] general_purpose_pins_i,
  input wire logic [3:0] general_purpose_pins_o,
  input wire logic [3:0] general_purpose_pins_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_take;
    tx_valid && tx_ready && !host_control_command_bypass;
  endsequence
  a_take_start: assert property (s_take |=> !uart_tx_o && !tx_ready)
    else $error("no start bit after take");
  a_ready_cts: assert property (flow_ctrl_en && tx_ready |-> !$past(uart_cts_n_i, 2))
    else $error("ready while cts high");
  a_rts_full: assert property (flow_ctrl_en && !rx_ready && !deep_sleep
    && !host_control_command_bypass |=> uart_rts_n_o) else $error("rts low without room");
  a_rts_off: assert property (!flow_ctrl_en && !deep_sleep
    && !host_control_command_bypass |=> !uart_rts_n_o) else $error("rts high with flow off");
  a_bypass_enter: assert property (host_control_command_bypass |=> deep_sleep)
    else $error("bypass not entered");
  a_sleep_hold: assert property (deep_sleep |=> deep_sleep)
    else $error("bypass left without reset");
  a_bypass_route: assert property (deep_sleep |-> general_purpose_pins_oe == 4'h5
    && uart_tx_o == general_purpose_pins_i[1] && uart_rts_n_o == general_purpose_pins_i[3]
    && general_purpose_pins_o[0] == uart_rx_i && general_purpose_pins_o[2] == uart_cts_n_i)
    else $error("bypass routing wrong");
  a_own_route: assert property (!deep_sleep |-> general_purpose_pins_oe == 4'h0)
    else $error("pins driven outside bypass");
  a_break_low: assert property (break_reset_req |-> !$past(uart_rx_i, 4))
    else $error("break request with line high");
endmodule

bind ubr_uart ubr_uart_monitor u_mon (
  .clk, .rst_n, .flow_ctrl_en, .host_control_command_bypass, .tx_valid, .tx_ready,
  .rx_ready, .break_reset_req, .deep_sleep, .uart_rx_i, .uart_tx_o, .uart_cts_n_i,
  .uart_rts_n_o, .general_purpose_pins_i, .general_purpose_pins_o,
  .general_purpose_pins_oe);

// [tb/ubr_uart_tb.sv]
/*
  self-checking bench for the serial port with break reset and bypass.
  assumes a 50 MHz clock; a divisor of 16 clocks per bit except in the rate tests.
*/
`timescale 1ns/1ps
module ubr_uart_tb;
  localparam int BIT = 16;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [15:0] tmo = 16'h0000;
  logic [15:0] div = 16'h3200;
  logic [1:0] pm = 2'h0;
  logic [7:0] td = 8'h00;
  logic [3:0] gpi = 4'h0;
  logic two = 1'h0, flow = 1'h0, brk = 1'h0, byp = 1'h0, tv = 1'h0, rr = 1'h1, cts_n = 1'h1;
  logic rdy, rxv, perr, ferr, brq, slp, rxl, txo, txoe, rtso, rtsoe;
  logic [7:0] rxd;
  logic [3:0] gpo, gpoe;
  int failures = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  ubr_uart #(.MS_CYCLES(10)) dut (.clk(clk), .rst_n(rst_n), .baud_divisor_setting(div),
    .parity_mode(pm), .two_stop_bits(two), .flow_ctrl_en(flow),
    .break_reset_timeout_setting(tmo), .send_break(brk), .host_control_command_bypass(byp),
    .tx_data(td), .tx_valid(tv), .tx_ready(rdy), .rx_data(rxd), .rx_valid(rxv),
    .rx_parity_err(perr), .rx_frame_err(ferr), .rx_ready(rr), .break_reset_req(brq),
    .deep_sleep(slp), .uart_rx_i(rxl), .uart_tx_o(txo), .uart_tx_oe(txoe),
    .uart_cts_n_i(cts_n), .uart_rts_n_o(rtso), .uart_rts_n_oe(rtsoe),
    .general_purpose_pins_i(gpi), .general_purpose_pins_o(gpo), .general_purpose_pins_oe(gpoe));
  ubr_serial_peer #(.BIT(BIT)) peer (.clk(clk), .line_in(txo), .line_out(rxl));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t check %0d got %h exp %h", $time, total_checks, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one character each way at once, counting break requests
  task automatic t_char(input logic [7:0] d, input logic [1:0] p, input logic s2, bad, stp,
      input logic [15:0] t, input int e);
    logic [10:0] s;
    logic [9:0] r;
    int n, c, k, nb;
    n = 0;
    c = 0;
    k = 0;
    nb = 10 + (p != ubr_pkg::PAR_NONE) + s2;
    pm = p;
    two = s2;
    tmo = t;
    td = d;
    tv = 1'h1;
    fork
      peer.recv(s);
      peer.send(d, p, bad, stp);
      begin
        @(negedge clk);
        tv = 1'h0;
        repeat (220) begin
          @(negedge clk);
          n += (rdy !== 1'h1);
          c += (brq === 1'h1);
          k += (rxv === 1'h1);
          if (rxv === 1'h1 && k == 1)
            r = {ferr, perr, rxd};
        end
      end
    join
    repeat (stp ? 2 : 200) @(negedge clk);
    chk(s[8:0], {d, 1'h0});
    chk(s[9], p == ubr_pkg::PAR_NONE ? 1'h1 : ^d ^ (p == ubr_pkg::PAR_ODD));
    chk(n >= nb * BIT - 3 && n <= nb * BIT + 1, 1'h1);
    chk(r, {!stp, bad, d});
    chk(c, e);
  endtask
  // reset held for hold cycles, pins float, then own port with idle line
  task automatic t_reset(input int hold);
    rst_n = 1'h0;
    repeat (hold) @(negedge clk);
    chk({txoe, rtsoe, gpoe}, 6'h00);
    rst_n = 1'h1;
    repeat (2) @(negedge clk);
    chk({txoe, rtsoe, slp, gpoe, txo}, 8'hC1);
  endtask
  // bit time follows the divisor, one tick of start phase allowed
  task automatic t_rate(input logic [15:0] dv);
    int n, e;
    n = 0;
    e = 10 * ubr_pkg::ACC_MOD / dv;
    div = dv;
    pm = ubr_pkg::PAR_NONE;
    two = 1'h0;
    td = 8'h3C;
    tv = 1'h1;
    @(negedge clk);
    tv = 1'h0;
    while (rdy !== 1'h1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    chk(n >= e - e / 80 - e / 100 - 2 && n <= e + e / 100 + 2, 1'h1);
    div = 16'h3200;
  endtask
  // active-low flow control in both directions, then none
  task automatic t_flow();
    flow = 1'h1;
    rr = 1'h0;
    repeat (4) @(negedge clk);
    chk({rdy, rtso}, 2'h1);
    cts_n = 1'h0;
    rr = 1'h1;
    repeat (4) @(negedge clk);
    chk({rdy, rtso}, 2'h2);
    flow = 1'h0;
    cts_n = 1'h1;
    repeat (2) @(negedge clk);
    chk({rdy, rtso}, 2'h2);
  endtask
  // break held low while asked for, then idle high
  task automatic break_low_duration();
    brk = 1'h1;
    repeat (3) @(negedge clk);
    chk({txo, rdy}, 2'h0);
    brk = 1'h0;
    repeat (3) @(negedge clk);
    chk({txo, rdy}, 2'h3);
  endtask
  // no traffic in flight when bypass is asked for
  task automatic t_bypass();
    byp = 1'h1;
    @(negedge clk);
    byp = 1'h0;
    gpi = 4'hA;
    cts_n = 1'h0;
    @(negedge clk);
    chk({slp, rdy, gpoe, txo, rtso, gpo}, 12'h971);
    gpi = 4'h0;
    cts_n = 1'h1;
    repeat (20) @(negedge clk);
    chk({slp, txo, rtso, gpo}, 7'h45);
  endtask
  initial begin
    t_reset(3);
    for (int p = 0; p < 3; p++) begin
      t_char(8'hA5 ^ p[7:0], p[1:0], p[0], 1'h0, 1'h1, 16'h0000, 0);
    end
    t_char(8'h00, ubr_pkg::PAR_EVEN, 1'h0, 1'h1, 1'h1, 16'h000F, 0);
    t_char(8'h00, ubr_pkg::PAR_NONE, 1'h1, 1'h0, 1'h0, 16'h000E, 1);
    t_rate(ubr_pkg::DIV_921600);
    t_rate(ubr_pkg::DIV_115200);
    t_flow();
    break_low_duration();
    t_bypass();
    t_reset(2);
    conclude();
  end
  initial begin
    #400_000;
    failures++;
    conclude();
  end
endmodule
